/* hdl/ilpc_ctrl.sv */
// exception, wait and stop control of the processor core
`timescale 1ns/1ps
module ilpc_ctrl
	import ilpc_pkg::*;
(
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic                    powerOnReset,
	// pins
	input  wire logic                    maskPin_n,
	input  wire logic                    nonmaskable_request_pin_n,
	input  wire logic                    edgeReqPending,
	// peripheral flags and local enables
	input  wire logic [NUM_MASKABLE-2:0] periphFlag,
	input  wire logic [NUM_MASKABLE-2:0] periphEnable,
	// core sequencer
	input  wire logic                    instrDone,
	input  wire logic                    illegalOpcode,
	input  wire logic                    softTrapExec,
	input  wire logic                    standbyExec,
	input  wire logic                    stopExec,
	input  wire logic                    haltGateFlag,
	input  wire logic                    stackDone,
	input  wire logic                    vectorDone,
	input  wire logic                    returnExec,
	input  wire logic                    pulledGateFlag,
	input  wire logic                    pulledMaskFlag,
	input  wire logic                    flagWrite,
	input  wire logic                    flagWriteGate,
	input  wire logic                    flagWriteMask,
	input  wire logic [15:0]             opcodeAddr,
	input  wire logic [15:0]             nextPc,
	input  wire logic [15:0]             stackedFlagAddr,
	// configuration
	input  wire logic                    restart_delay_enable_wr,
	input  wire logic                    restart_delay_enable_val,
	input  wire logic                    watchdog_disable_bit,
	// status and commands
	output logic                         gateFlag,
	output logic                         maskFlag,
	output logic                         restartDelayEnable,
	output logic                         stackReq,
	output logic [15:0]                  returnAddr,
	output logic                         vectorReq,
	output logic [VEC_W-1:0]             vectorSel,
	output logic [SRC_W-1:0]             vectorSrc,
	output logic                         cpuHalt,
	output logic                         waitRead,
	output logic [15:0]                  waitAddr,
	output logic                         timerRun,
	output logic                         clocksRun,
	output logic                         oscRun
);

	ilpc_state_e           state;
	ilpc_state_e           next_state;
	logic                  next_gateFlag;
	logic                  next_maskFlag;
	logic                  next_restartDelayEnable;
	logic                  next_stackReq;
	logic [15:0]           next_returnAddr;
	logic                  next_vectorReq;
	logic [VEC_W-1:0]      next_vectorSel;
	logic [SRC_W-1:0]      next_vectorSrc;
	logic                  next_cpuHalt;
	logic                  next_waitRead;
	logic [15:0]           next_waitAddr;
	logic                  next_timerRun;
	logic                  next_clocksRun;
	logic                  next_oscRun;
	logic [DLY_W-1:0]      dlyCnt;
	logic [DLY_W-1:0]      next_dlyCnt;
	logic [VEC_W-1:0]      pendVec;
	logic [VEC_W-1:0]      next_pendVec;
	logic                  stopNoService;
	logic                  next_stopNoService;
	logic [NUM_MASKABLE-1:0] maskReq;
	logic [VEC_W-1:0]      prioVec;
	logic [SRC_W-1:0]      prioSrc;
	logic                  prioAny;
	logic                  nmiLevel;
	logic                  stopWake;

	// ************************************************************
	// request gathering
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_MASKABLE - 1; g++) begin : gPer
			assign maskReq[g + 1] = periphFlag[g] & periphEnable[g];
		end
	endgenerate
	assign maskReq[0] = ~maskPin_n;
	assign nmiLevel   = ~nonmaskable_request_pin_n;

	ilpc_prio uPrio (
		.maskReq  (maskReq),
		.maskFlag (maskFlag),
		.nmiReq   (nmiLevel),
		.gateFlag (gateFlag),
		.vecSel   (prioVec),
		.srcIdx   (prioSrc),
		.anyReq   (prioAny)
	);

	// stop wake sources
	assign stopWake = nmiLevel
		| ((~maskPin_n | edgeReqPending) & ~maskFlag);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_state              = state;
		next_gateFlag           = gateFlag;
		next_maskFlag           = maskFlag;
		next_restartDelayEnable = restartDelayEnable;
		next_stackReq           = 1'b0;
		next_returnAddr         = returnAddr;
		next_vectorReq          = 1'b0;
		next_vectorSel          = vectorSel;
		next_vectorSrc          = vectorSrc;
		next_cpuHalt            = cpuHalt;
		next_waitRead           = waitRead;
		next_waitAddr           = waitAddr;
		next_timerRun           = 1'b1;
		next_clocksRun          = clocksRun;
		next_oscRun             = oscRun;
		next_dlyCnt             = dlyCnt;
		next_pendVec            = pendVec;
		next_stopNoService      = stopNoService;
		if (flagWrite) begin
			next_maskFlag = flagWriteMask;
			if (!flagWriteGate)
				next_gateFlag = 1'b0;
		end
		if (restart_delay_enable_wr)
			next_restartDelayEnable = restart_delay_enable_val;
		unique case (state)
			ST_RUN: begin
				if (returnExec) begin
					next_gateFlag = pulledGateFlag;
					next_maskFlag = pulledMaskFlag;
				end else if (illegalOpcode) begin
					next_pendVec    = VEC_ILLEGAL;
					next_returnAddr = opcodeAddr;
					next_vectorSrc  = SRC_NONE;
					next_stackReq   = 1'b1;
					next_state      = ST_STACK;
				end else if (softTrapExec) begin
					next_pendVec    = VEC_SOFT_TRAP;
					next_vectorSrc  = SRC_NONE;
					next_returnAddr = nextPc;
					next_stackReq   = 1'b1;
					next_state      = ST_STACK;
				end else if (standbyExec) begin
					next_pendVec    = VEC_NONE;
					next_returnAddr = nextPc;
					next_stackReq   = 1'b1;
					next_state      = ST_STACK;
				end else if (stopExec && !haltGateFlag) begin
					next_cpuHalt   = 1'b1;
					next_clocksRun = 1'b0;
					next_oscRun    = 1'b0;
					next_state     = ST_STOP;
				end else if (instrDone && prioAny) begin
					next_pendVec    = prioVec;
					next_vectorSrc  = prioSrc;
					next_returnAddr = nextPc;
					next_stackReq   = 1'b1;
					next_state      = ST_STACK;
				end
			end
			ST_STACK: begin
				if (stackDone) begin
					if (pendVec == VEC_NONE) begin
						next_cpuHalt  = 1'b1;
						next_waitRead = 1'b1;
						next_waitAddr = stackedFlagAddr;
						next_state    = ST_WAIT;
					end else begin
						next_maskFlag = 1'b1;
						if (pendVec == VEC_NONMASKABLE)
							next_gateFlag = 1'b1;
						next_vectorReq = 1'b1;
						next_vectorSel = pendVec;
						next_state     = ST_VEC;
					end
				end
			end
			ST_WAIT: begin
				next_timerRun = !(maskFlag && watchdog_disable_bit);
				if (prioAny) begin
					next_maskFlag = 1'b1;
					if (prioVec == VEC_NONMASKABLE)
						next_gateFlag = 1'b1;
					next_vectorSel = prioVec;
					next_vectorSrc = prioSrc;
					next_vectorReq = 1'b1;
					next_cpuHalt   = 1'b0;
					next_waitRead  = 1'b0;
					next_state     = ST_VEC;
				end
			end
			ST_STOP: begin
				next_timerRun = 1'b0;
				if (stopWake) begin
					next_oscRun        = 1'b1;
					next_stopNoService = gateFlag;
					next_dlyCnt        = DLY_W'(OSC_DELAY_CYC);
					if (restartDelayEnable) begin
						next_state = ST_OSC;
					end else begin
						next_clocksRun = 1'b1;
						next_cpuHalt   = 1'b0;
						next_state     = ST_RUN;
					end
				end
			end
			ST_OSC: begin
				next_timerRun = 1'b0;
				if (dlyCnt <= DLY_W'(1)) begin
					next_clocksRun = 1'b1;
					next_cpuHalt   = 1'b0;
					next_state     = ST_RUN;
				end else begin
					next_dlyCnt = dlyCnt - DLY_W'(1);
				end
			end
			ST_VEC: begin
				if (vectorDone)
					next_state = ST_RUN;
			end
			default: next_state = ST_RUN;
		endcase
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state              <= powerOnReset ? ST_OSC : ST_RUN;
			gateFlag           <= RST_GATE_FLAG;
			maskFlag           <= RST_MASK_FLAG;
			restartDelayEnable <= RST_DELAY_ENABLE;
			stackReq           <= 1'b0;
			returnAddr         <= 16'h0000;
			vectorReq          <= 1'b0;
			vectorSel          <= VEC_NONE;
			vectorSrc          <= SRC_NONE;
			cpuHalt            <= powerOnReset;
			waitRead           <= 1'b0;
			waitAddr           <= 16'h0000;
			timerRun           <= 1'b1;
			clocksRun          <= ~powerOnReset;
			oscRun             <= 1'b1;
			dlyCnt             <= powerOnReset ? DLY_W'(OSC_DELAY_CYC) : {DLY_W{1'b0}};
			pendVec            <= VEC_NONE;
			stopNoService      <= 1'b0;
		end else begin
			state              <= next_state;
			gateFlag           <= next_gateFlag;
			maskFlag           <= next_maskFlag;
			restartDelayEnable <= next_restartDelayEnable;
			stackReq           <= next_stackReq;
			returnAddr         <= next_returnAddr;
			vectorReq          <= next_vectorReq;
			vectorSel          <= next_vectorSel;
			vectorSrc          <= next_vectorSrc;
			cpuHalt            <= next_cpuHalt;
			waitRead           <= next_waitRead;
			waitAddr           <= next_waitAddr;
			timerRun           <= next_timerRun;
			clocksRun          <= next_clocksRun;
			oscRun             <= next_oscRun;
			dlyCnt             <= next_dlyCnt;
			pendVec            <= next_pendVec;
			stopNoService      <= next_stopNoService;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	chk_reset_flags: assert property (@(posedge mclk)
		$past(rst) |-> gateFlag && maskFlag)
		else $error("mask flags not set after reset");
	chk_gate_sticky: assert property (@(posedge mclk) disable iff (rst)
		!$past(gateFlag) && gateFlag |-> $past(state) inside {ST_STACK, ST_WAIT}
			|| $past(returnExec))
		else $error("gate flag set by software");
	chk_nmi_rank: assert property (@(posedge mclk) disable iff (rst)
		nmiLevel && !gateFlag |-> prioVec == VEC_NONMASKABLE)
		else $error("nonmaskable not ranked first");
	chk_mask_service: assert property (@(posedge mclk) disable iff (rst)
		state == ST_STACK && stackDone && pendVec == VEC_MASKABLE && !flagWrite
		|=> maskFlag && gateFlag == $past(gateFlag) && vectorReq)
		else $error("maskable service flags wrong");
	chk_nmi_service: assert property (@(posedge mclk) disable iff (rst)
		state == ST_STACK && stackDone && pendVec == VEC_NONMASKABLE
		|=> gateFlag && maskFlag)
		else $error("nonmaskable service flags wrong");
	chk_return_pull: assert property (@(posedge mclk) disable iff (rst)
		state == ST_RUN && returnExec && !flagWrite
		|=> maskFlag == $past(pulledMaskFlag) && gateFlag == $past(pulledGateFlag))
		else $error("return did not restore flags");
	chk_illegal_addr: assert property (@(posedge mclk) disable iff (rst)
		state == ST_RUN && illegalOpcode && !returnExec
		|=> stackReq && returnAddr == $past(opcodeAddr))
		else $error("illegal trap address wrong");
	chk_stop_gate: assert property (@(posedge mclk) disable iff (rst)
		state == ST_RUN && stopExec && haltGateFlag |=> state != ST_STOP)
		else $error("stop entered with halt gate set");
	chk_timer_wait: assert property (@(posedge mclk) disable iff (rst)
		state == ST_WAIT && $past(state) == ST_WAIT && !$past(maskFlag) |-> timerRun)
		else $error("timer stopped in wait while unmasked");
	chk_wait_exit: assert property (@(posedge mclk) disable iff (rst)
		state == ST_WAIT && prioAny |=> state == ST_VEC && vectorReq && !stackReq)
		else $error("wait not left on request");
	chk_stop_resume: assert property (@(posedge mclk) disable iff (rst)
		state == ST_RUN && $past(state) inside {ST_STOP, ST_OSC} && stopNoService
		|-> prioVec != VEC_NONMASKABLE)
		else $error("nonmaskable pending after stop resume");

endmodule : ilpc_ctrl

/* hdl/ilpc_pkg.sv */
// package of constants and types for the interrupt and low-power control block
package ilpc_pkg;

	// ************************************************************
	// source indices and widths
	// ************************************************************
	localparam int          NUM_MASKABLE       = 15;
	localparam int          SRC_W              = 4;
	localparam logic [3:0]  SRC_NONE           = 4'hF;
	localparam int          VEC_W              = 3;

	// ************************************************************
	// vector selectors
	// ************************************************************
	localparam logic [2:0]  VEC_NONE           = 3'h0;
	localparam logic [2:0]  VEC_MASKABLE       = 3'h1;
	localparam logic [2:0]  VEC_NONMASKABLE    = 3'h2;
	localparam logic [2:0]  VEC_SOFT_TRAP      = 3'h3;
	localparam logic [2:0]  VEC_ILLEGAL        = 3'h4;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic        RST_GATE_FLAG      = 1'b1;
	localparam logic        RST_MASK_FLAG      = 1'b1;
	localparam logic        RST_DELAY_ENABLE   = 1'b1;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int          CLK_PERIOD_NS      = 8;
	localparam int          OSC_DELAY_NS       = 32000;
	localparam int          OSC_DELAY_CYC      = (OSC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          DLY_W              = 16;

	// ************************************************************
	// control state
	// ************************************************************
	typedef enum logic [2:0] {
		ST_RUN   = 3'b000,
		ST_STACK = 3'b001,
		ST_WAIT  = 3'b010,
		ST_STOP  = 3'b011,
		ST_OSC   = 3'b100,
		ST_VEC   = 3'b101
	} ilpc_state_e;

endpackage : ilpc_pkg

/* hdl/ilpc_prio.sv */
// priority resolver for pending exception sources
`timescale 1ns/1ps
module ilpc_prio
	import ilpc_pkg::*;
(
	// maskable sources
	input  wire logic [NUM_MASKABLE-1:0] maskReq,
	input  wire logic                    maskFlag,
	// nonmaskable sources
	input  wire logic                    nmiReq,
	input  wire logic                    gateFlag,
	// result
	output logic      [VEC_W-1:0]        vecSel,
	output logic      [SRC_W-1:0]        srcIdx,
	output logic                         anyReq
);

	logic [SRC_W-1:0] lowIdx;
	logic             anyMask;

	// ************************************************************
	// lowest index wins among maskable sources
	// ************************************************************
	always_comb begin
		lowIdx  = SRC_NONE;
		anyMask = 1'b0;
		for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
			if (maskReq[i]) begin
				lowIdx  = SRC_W'(i);
				anyMask = 1'b1;
			end
		end
	end

	// ************************************************************
	// nonmaskable ranks above all maskable
	// ************************************************************
	always_comb begin
		vecSel = VEC_NONE;
		srcIdx = SRC_NONE;
		if (nmiReq && !gateFlag) begin
			vecSel = VEC_NONMASKABLE;
		end else if (anyMask && !maskFlag) begin
			vecSel = VEC_MASKABLE;
			srcIdx = lowIdx;
		end
		anyReq = (vecSel != VEC_NONE);
	end

endmodule : ilpc_prio

/* test/ilpc_core_model.sv */
// core sequencer model answering stack and vector requests
`timescale 1ns/1ps
module ilpc_core_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// requests and pace
	input  wire logic stackReq,
	input  wire logic vectorReq,
	input  wire logic slow,
	// answers
	output logic      stackDone,
	output logic      vectorDone
);
	int sCnt;
	int vCnt;
	// ************************************************************
	// stack, then answer after a short or long pause
	// ************************************************************
	always @(posedge mclk) begin
		stackDone  <= 1'b0;
		vectorDone <= 1'b0;
		if (rst) begin
			sCnt <= 0;
			vCnt <= 0;
		end else begin
			if (stackReq)
				sCnt <= slow ? 9 : 2;
			else if (sCnt > 1)
				sCnt <= sCnt - 1;
			else if (sCnt == 1) begin
				stackDone <= 1'b1;
				sCnt      <= 0;
			end
			if (vectorReq)
				vCnt <= slow ? 7 : 1;
			else if (vCnt > 1)
				vCnt <= vCnt - 1;
			else if (vCnt == 1) begin
				vectorDone <= 1'b1;
				vCnt       <= 0;
			end
		end
	end
endmodule : ilpc_core_model

/* test/ilpc_ctrl_test.sv */
// self-checking bench for the exception and low-power control
`timescale 1ns/1ps
module ilpc_ctrl_test
	import ilpc_pkg::*;
;
	logic mclk, rst, por, maskPin_n, nmiPin_n, edgeReq, instrDone, illegalOpcode;
	logic softTrapExec, standbyExec, stopExec, haltGateFlag, stackDone, vectorDone;
	logic returnExec, pulledGateFlag, pulledMaskFlag, flagWrite, flagWriteGate;
	logic flagWriteMask, dlyWr, dlyVal, wdogOff, slow;
	logic [NUM_MASKABLE-2:0] periphFlag, periphEnable;
	logic [15:0] opcodeAddr, nextPc, stackedFlagAddr, returnAddr, waitAddr;
	logic gateFlag, maskFlag, restartDelayEnable, stackReq, vectorReq;
	logic cpuHalt, waitRead, timerRun, clocksRun, oscRun;
	logic [VEC_W-1:0] vectorSel;
	logic [SRC_W-1:0] vectorSrc;
	int fail_count, checked, stackCount, vecCount, i, s0, v0;

	ilpc_ctrl uut (.mclk(mclk), .rst(rst), .powerOnReset(por), .maskPin_n(maskPin_n),
		.nonmaskable_request_pin_n(nmiPin_n), .edgeReqPending(edgeReq),
		.periphFlag(periphFlag), .periphEnable(periphEnable), .instrDone(instrDone),
		.illegalOpcode(illegalOpcode), .softTrapExec(softTrapExec),
		.standbyExec(standbyExec), .stopExec(stopExec), .haltGateFlag(haltGateFlag),
		.stackDone(stackDone), .vectorDone(vectorDone), .returnExec(returnExec),
		.pulledGateFlag(pulledGateFlag), .pulledMaskFlag(pulledMaskFlag),
		.flagWrite(flagWrite), .flagWriteGate(flagWriteGate),
		.flagWriteMask(flagWriteMask), .opcodeAddr(opcodeAddr), .nextPc(nextPc),
		.stackedFlagAddr(stackedFlagAddr), .restart_delay_enable_wr(dlyWr),
		.restart_delay_enable_val(dlyVal), .watchdog_disable_bit(wdogOff),
		.gateFlag(gateFlag), .maskFlag(maskFlag), .restartDelayEnable(restartDelayEnable),
		.stackReq(stackReq), .returnAddr(returnAddr), .vectorReq(vectorReq),
		.vectorSel(vectorSel), .vectorSrc(vectorSrc), .cpuHalt(cpuHalt),
		.waitRead(waitRead), .waitAddr(waitAddr), .timerRun(timerRun),
		.clocksRun(clocksRun), .oscRun(oscRun));

	ilpc_core_model core (.mclk(mclk), .rst(rst), .stackReq(stackReq),
		.vectorReq(vectorReq), .slow(slow), .stackDone(stackDone), .vectorDone(vectorDone));

	// ************************************************************
	// clock, event counters, watchdog
	// ************************************************************
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (stackReq === 1'b1) stackCount++;
		if (vectorReq === 1'b1) vecCount++;
	end
	initial begin
		#400000;
		fail_count++;
		report_and_stop();
	end

	// ************************************************************
	// helper tasks
	// ************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_bit
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic go(input int k);
		case (k)
			0: instrDone = 1'b1;
			1: illegalOpcode = 1'b1;
			2: softTrapExec = 1'b1;
			3: standbyExec = 1'b1;
			4: stopExec = 1'b1;
			5: returnExec = 1'b1;
			default: flagWrite = 1'b1;
		endcase
		tick(1);
		{instrDone, illegalOpcode, softTrapExec, standbyExec, stopExec} = 5'h00;
		{returnExec, flagWrite} = 2'h0;
	endtask : go
	task automatic ret(input logic g, input logic m);
		pulledGateFlag = g;
		pulledMaskFlag = m;
		go(5);
		tick(1);
	endtask : ret
	task automatic wr(input logic g, input logic m);
		flagWriteGate = g;
		flagWriteMask = m;
		go(6);
		tick(1);
	endtask : wr
	task automatic serve(input logic [15:0] sel, input logic [15:0] src);
		int n;
		n = 0;
		while (vectorReq !== 1'b1 && n < 60) begin
			tick(1);
			n++;
		end
		cmp_bit(vectorReq, 1'b1);
		cmp_word(16'(vectorSel), sel);
		cmp_word(16'(vectorSrc), src);
		n = 0;
		while (vectorDone !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		tick(1);
	endtask : serve
	task automatic report_and_stop();
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		{por, edgeReq, instrDone, illegalOpcode, softTrapExec, standbyExec} = 6'h00;
		{stopExec, haltGateFlag, returnExec, pulledGateFlag, pulledMaskFlag} = 5'h00;
		{flagWrite, flagWriteGate, flagWriteMask, dlyWr, dlyVal, slow} = 6'h00;
		{rst, maskPin_n, nmiPin_n, wdogOff} = 4'hF;
		{periphFlag, periphEnable} = '0;
		{opcodeAddr, nextPc, stackedFlagAddr} = {16'h1234, 16'h2000, 16'h01F7};
		{fail_count, checked, stackCount, vecCount} = {32'h0, 32'h0, 32'h0, 32'h0};
		tick(2);
		rst = 1'b0;
		tick(1);
		cmp_bit(gateFlag, 1'b1);
		cmp_bit(maskFlag, 1'b1);
		cmp_bit(restartDelayEnable, 1'b1);
		cmp_bit(clocksRun, 1'b1);
		wr(1'b0, 1'b0);
		cmp_bit(gateFlag, 1'b0);
		wr(1'b1, 1'b0);
		cmp_bit(gateFlag, 1'b0);
		maskPin_n = 1'b0;
		s0 = stackCount;
		go(0);
		cmp_bit(maskFlag, 1'b0);
		serve(16'h1, 16'h0);
		cmp_bit(maskFlag, 1'b1);
		cmp_bit(gateFlag, 1'b0);
		cmp_word(16'(stackCount - s0), 16'h1);
		ret(1'b0, 1'b0);
		cmp_bit(maskFlag, 1'b0);
		nmiPin_n = 1'b0;
		slow = 1'b1;
		go(0);
		serve(16'h2, 16'hF);
		cmp_bit(gateFlag, 1'b1);
		cmp_bit(maskFlag, 1'b1);
		{maskPin_n, nmiPin_n, slow} = 3'h6;
		ret(1'b0, 1'b0);
		cmp_bit(gateFlag, 1'b0);
		periphFlag[2] = 1'b1;
		periphEnable[2] = 1'b1;
		go(0);
		serve(16'h1, 16'h3);
		periphFlag[2] = 1'b0;
		ret(1'b0, 1'b0);
		go(1);
		tick(1);
		cmp_word(returnAddr, 16'h1234);
		serve(16'h4, 16'hF);
		ret(1'b0, 1'b0);
		wr(1'b0, 1'b1);
		go(2);
		serve(16'h3, 16'hF);
		cmp_word(returnAddr, 16'h2000);
		cmp_bit(maskFlag, 1'b1);
		ret(1'b0, 1'b0);
		for (i = 0; i < 2; i++) begin
			if (i == 1)
				wr(1'b0, 1'b1);
			go(3);
			tick(8);
			cmp_bit(cpuHalt, 1'b1);
			cmp_bit(waitRead, 1'b1);
			cmp_word(waitAddr, 16'h01F7);
			cmp_bit(oscRun, 1'b1);
			cmp_bit(timerRun, i == 0);
			s0 = stackCount;
			if (i == 0)
				periphFlag[2] = 1'b1;
			else
				nmiPin_n = 1'b0;
			serve(i == 0 ? 16'h1 : 16'h2, i == 0 ? 16'h3 : 16'hF);
			cmp_word(16'(stackCount - s0), 16'h0);
			cmp_bit(cpuHalt, 1'b0);
			{periphFlag[2], nmiPin_n} = 2'h1;
			ret(1'b0, 1'b0);
		end
		haltGateFlag = 1'b1;
		go(4);
		tick(2);
		cmp_bit(clocksRun, 1'b1);
		cmp_bit(cpuHalt, 1'b0);
		{dlyWr, dlyVal, haltGateFlag} = 3'h4;
		tick(1);
		dlyWr = 1'b0;
		tick(1);
		cmp_bit(restartDelayEnable, 1'b0);
		ret(1'b1, 1'b1);
		for (i = 0; i < 2; i++) begin
			go(4);
			tick(2);
			cmp_bit(clocksRun, 1'b0);
			cmp_bit(oscRun, 1'b0);
			cmp_bit(cpuHalt, 1'b1);
			{maskPin_n, edgeReq} = 2'h1;
			tick(10);
			cmp_bit(oscRun, 1'b0);
			{maskPin_n, nmiPin_n, edgeReq} = 3'h4;
			{s0, v0} = {stackCount, vecCount};
			tick(1);
			while (clocksRun !== 1'b1 && s0 < 4100 + stackCount) begin
				tick(1);
				s0++;
			end
			s0 = s0 - stackCount;
			if (i == 0)
				cmp_bit(s0 <= 3, 1'b1);
			else
				cmp_bit(s0 >= OSC_DELAY_CYC - 3 && s0 <= OSC_DELAY_CYC + 3, 1'b1);
			go(0);
			nmiPin_n = 1'b1;
			tick(12);
			cmp_bit(cpuHalt, 1'b0);
			cmp_word(16'(vecCount - v0), 16'h0);
			{dlyWr, dlyVal} = 2'h3;
			tick(1);
			dlyWr = 1'b0;
		end
		ret(1'b0, 1'b0);
		go(4);
		edgeReq = 1'b1;
		tick(1);
		cmp_bit(oscRun, 1'b1);
		{rst, por, edgeReq} = 3'h6;
		tick(2);
		{rst, por} = 2'h0;
		tick(1);
		cmp_bit(gateFlag, 1'b1);
		cmp_bit(clocksRun, 1'b0);
		cmp_bit(cpuHalt, 1'b1);
		s0 = 1;
		while (clocksRun !== 1'b1 && s0 < 4100) begin
			tick(1);
			s0++;
		end
		cmp_bit(s0 >= OSC_DELAY_CYC - 3 && s0 <= OSC_DELAY_CYC + 3, 1'b1);
		report_and_stop();
	end
endmodule : ilpc_ctrl_test
